// *** logic/cpu_periph_clock_select.sv ***
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Operation
// - flags report CPU source, sub overrides main
// - clearing sub enable stops external, and crystal unless pin override is set
// - STOP mode leaves subsystem oscillation running
// - low-speed clock never drives CPU
// - low-speed starts after reset, feeds watchdog
// - stop bit halts low-speed unless locked
// - clearing stop bit restarts low-speed oscillator
// - locked option ignores low-speed stop bit
// - source select picks peripheral and main clock
// - sub select picks CPU clock only
// - external select picks crystal or input
// - reset leaves everything on internal high-speed
// - oscillator mode field positions fixed
// - control field positions fixed
// - high-speed stop only when CPU elsewhere
// - gain bit changes once per reset
module cpu_periph_clock_select (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // raw oscillator levels from the pads and analog cells
   input wire logic hs_osc_clk,
   input wire logic x1_clk,
   input wire logic ext_main_clk,
   input wire logic sub_xt_clk,
   input wire logic sub_ext_clk,
   input wire logic lowspeed_clk,
   // option byte and core status, same domain
   input wire logic opt_wdt_enable,
   input wire logic opt_lowspeed_locked,
   input wire logic stop_mode,
   input wire logic timer8_use_lowspeed,
   // oscillator enables
   output logic hs_osc_enable,
   output logic main_xtal_enable,
   output logic main_ext_enable,
   output logic sub_xtal_enable,
   output logic sub_ext_enable,
   output logic lowspeed_osc_enable,
   // switched clocks
   output logic cpu_clk,
   output logic periph_clk,
   output logic wdt_clk,
   output logic timer8_clk
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic waitreq;      // bus wait level
      logic [7:0] rdata;  // read data byte
      logic src_sel;      // main_source_select
      logic cpu_src;      // main_cpu_source_select
      logic cpu_sub;      // cpu_sub_select
      logic pin_ovr;      // sub_pin_override
      logic ext_main;     // main_ext_clock_select
      logic pins_osc;     // main_pins_osc_mode
      logic sub_ext;      // sub_ext_clock_select
      logic sub_en;       // sub_osc_enable
      logic amp_hi;       // main_amp_high_gain
      logic amp_locked;   // gain already changed since reset
      logic main_stop;    // main_clock_stop
      logic hs_stop;      // internal_hs_stop
      logic ls_stop;      // lowspeed_osc_stop
      logic opt_taken;    // option byte captured
      logic opt_wdt;      // captured watchdog enable
      logic opt_lock;     // captured non-stoppable setting
      logic [7:0] settle; // main_osc_settle_counter
      logic x1_prev;      // last sampled crystal level
      logic hs_en;
      logic mx_en;
      logic me_en;
      logic sx_en;
      logic se_en;
      logic ls_en;
      logic wdt;
      logic tmr;
   } state_type;
   state_type st_reg, st_next;

   logic [clk_sel_pkg::NUM_SYNC-1:0] raw; // unsynchronised oscillator levels
   logic [clk_sel_pkg::NUM_SYNC-1:0] smp; // synchronised oscillator levels
   logic [clk_sel_pkg::NUM_SRC-1:0] srcs; // gated sources for both switches
   logic [1:0] cpu_sel; // wanted CPU source
   logic [1:0] per_sel; // wanted peripheral source
   logic [1:0] cpu_cur; // CPU source in use
   logic [1:0] per_cur; // peripheral source in use
   logic we;            // write takes effect this edge
   logic sub_xt_run;    // subsystem crystal mode active
   logic sub_ex_run;    // subsystem external input active

   // ---------------------------------------------------------------
   // oscillator sampling
   // ---------------------------------------------------------------
   assign raw = {lowspeed_clk, sub_ext_clk, sub_xt_clk, ext_main_clk, x1_clk, hs_osc_clk};

   // every oscillator level crosses into mclk through two flops
   genvar gi;
   generate
      for (gi = 0; gi < clk_sel_pkg::NUM_SYNC; gi++) begin : g_sync
         sync2 u_sync (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .din(raw[gi]),
            .dout(smp[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // source gating and selection
   // ---------------------------------------------------------------
   // subsystem pin modes: override or register crystal mode, or external input
   assign sub_xt_run = st_reg.pin_ovr || (st_reg.sub_en && !st_reg.sub_ext);
   assign sub_ex_run = !st_reg.pin_ovr && st_reg.sub_en && st_reg.sub_ext;

   // a stopped source reads low, so the switch may still leave it
   always_comb begin
      srcs[clk_sel_pkg::SRC_HS] = smp[0] && st_reg.hs_en;
      srcs[clk_sel_pkg::SRC_X1] = smp[1] && st_reg.mx_en;
      srcs[clk_sel_pkg::SRC_EXT] = smp[2] && st_reg.me_en;
      srcs[clk_sel_pkg::SRC_SUB] = (smp[3] && st_reg.sx_en) || (smp[4] && st_reg.se_en);
   end

   // high-speed system source from the external select
   function automatic logic [1:0] hsys_src(input logic ext);
      hsys_src = ext ? clk_sel_pkg::SRC_EXT : clk_sel_pkg::SRC_X1;
   endfunction : hsys_src

   // low-speed clock has no code here, so it can never reach the CPU
   always_comb begin
      per_sel = st_reg.src_sel ? hsys_src(st_reg.ext_main) : clk_sel_pkg::SRC_HS;
      if (st_reg.cpu_sub) begin
         cpu_sel = clk_sel_pkg::SRC_SUB;
      end else if (st_reg.src_sel && st_reg.cpu_src) begin
         cpu_sel = hsys_src(st_reg.ext_main);
      end else begin
         cpu_sel = clk_sel_pkg::SRC_HS;
      end
   end

   glitch_free_mux u_cpu_mux (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .src(srcs),
      .sel(cpu_sel),
      .clk_out(cpu_clk),
      .cur(cpu_cur)
   );

   glitch_free_mux u_per_mux (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .src(srcs),
      .sel(per_sel),
      .clk_out(periph_clk),
      .cur(per_cur)
   );

   // ---------------------------------------------------------------
   // register read decode
   // ---------------------------------------------------------------
   // one decode for every readable register, used by the read path
   function automatic logic [7:0] reg_read(input state_type s, input logic [7:0] a, input logic [1:0] cc);
      reg_read = clk_sel_pkg::BYTE_ZERO;
      unique case (a)
         clk_sel_pkg::OFF_MAIN_MODE: begin
            reg_read[clk_sel_pkg::B_SRC_SEL] = s.src_sel;
            reg_read[clk_sel_pkg::B_CPU_SRC] = s.cpu_src;
            // flag follows the switch while on main, the request while on sub
            reg_read[clk_sel_pkg::B_MAIN_HS] = (cc == clk_sel_pkg::SRC_SUB) ? (s.src_sel && s.cpu_src) :
                                               (cc != clk_sel_pkg::SRC_HS);
         end
         clk_sel_pkg::OFF_CPU_CTRL: begin
            reg_read[clk_sel_pkg::B_PIN_OVR] = s.pin_ovr;
            reg_read[clk_sel_pkg::B_ON_SUB] = (cc == clk_sel_pkg::SRC_SUB);
            reg_read[clk_sel_pkg::B_CPU_SUB] = s.cpu_sub;
         end
         clk_sel_pkg::OFF_OSC_MODE: begin
            reg_read[clk_sel_pkg::B_EXT_MAIN] = s.ext_main;
            reg_read[clk_sel_pkg::B_PINS_OSC] = s.pins_osc;
            reg_read[clk_sel_pkg::B_SUB_EXT] = s.sub_ext;
            reg_read[clk_sel_pkg::B_SUB_EN] = s.sub_en;
            reg_read[clk_sel_pkg::B_AMP_HI] = s.amp_hi;
         end
         clk_sel_pkg::OFF_MAIN_OSC: begin
            reg_read[clk_sel_pkg::B_MAIN_STOP] = s.main_stop;
         end
         clk_sel_pkg::OFF_INT_OSC: begin
            reg_read[clk_sel_pkg::B_HS_READY] = s.hs_en;
            reg_read[clk_sel_pkg::B_LS_STOP] = s.ls_stop;
            reg_read[clk_sel_pkg::B_HS_STOP] = s.hs_stop;
         end
         clk_sel_pkg::OFF_SETTLE: begin
            reg_read = s.settle;
         end
         default: begin
            reg_read = clk_sel_pkg::BYTE_ZERO; // unmapped reads as zero
         end
      endcase
   endfunction : reg_read

   // a write lands on the edge where the master sees waitrequest low
   assign we = write && !st_reg.waitreq && byteenable[0];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      // bus handshake: one wait cycle, then a one-cycle answer
      if ((read || write) && st_reg.waitreq) begin
         st_next.waitreq = 1'h0;
         st_next.rdata = reg_read(st_reg, address, cpu_cur);
      end else begin
         st_next.waitreq = 1'h1;
      end
      // option byte captured once, one cycle after reset release
      if (!st_reg.opt_taken) begin
         st_next.opt_taken = 1'h1;
         st_next.opt_wdt = opt_wdt_enable;
         st_next.opt_lock = opt_lowspeed_locked;
      end
      // register writes
      if (we) begin
         unique case (address)
            clk_sel_pkg::OFF_MAIN_MODE: begin
               st_next.src_sel = writedata[clk_sel_pkg::B_SRC_SEL];
               st_next.cpu_src = writedata[clk_sel_pkg::B_CPU_SRC];
            end
            clk_sel_pkg::OFF_CPU_CTRL: begin
               st_next.pin_ovr = writedata[clk_sel_pkg::B_PIN_OVR];
               st_next.cpu_sub = writedata[clk_sel_pkg::B_CPU_SUB];
            end
            clk_sel_pkg::OFF_OSC_MODE: begin
               st_next.ext_main = writedata[clk_sel_pkg::B_EXT_MAIN];
               st_next.pins_osc = writedata[clk_sel_pkg::B_PINS_OSC];
               st_next.sub_ext = writedata[clk_sel_pkg::B_SUB_EXT];
               st_next.sub_en = writedata[clk_sel_pkg::B_SUB_EN];
               // gain may change once; later writes leave it alone
               if (!st_reg.amp_locked && writedata[clk_sel_pkg::B_AMP_HI] != st_reg.amp_hi) begin
                  st_next.amp_hi = writedata[clk_sel_pkg::B_AMP_HI];
                  st_next.amp_locked = 1'h1;
               end
            end
            clk_sel_pkg::OFF_MAIN_OSC: begin
               st_next.main_stop = writedata[clk_sel_pkg::B_MAIN_STOP];
            end
            clk_sel_pkg::OFF_INT_OSC: begin
               // a stop of the CPU's own clock would hang the core, so it is refused
               if (!writedata[clk_sel_pkg::B_HS_STOP] || cpu_cur != clk_sel_pkg::SRC_HS) begin
                  st_next.hs_stop = writedata[clk_sel_pkg::B_HS_STOP];
               end
               st_next.ls_stop = writedata[clk_sel_pkg::B_LS_STOP] && !st_reg.opt_lock;
            end
            default: begin
               st_next.rdata = st_reg.rdata; // unmapped write ignored
            end
         endcase
      end
      if (st_next.opt_lock) begin
         st_next.ls_stop = 1'h0;
      end
      // oscillator enables; STOP mode halts internal high-speed and main crystal only
      st_next.hs_en = !st_reg.hs_stop && !stop_mode;
      st_next.mx_en = st_reg.pins_osc && !st_reg.ext_main && !st_reg.main_stop && !stop_mode;
      st_next.me_en = st_reg.pins_osc && st_reg.ext_main && !st_reg.main_stop;
      st_next.sx_en = sub_xt_run;
      st_next.se_en = sub_ex_run;
      st_next.ls_en = !st_reg.ls_stop;
      // low-speed clock feeds only watchdog and the 8-bit timer
      st_next.wdt = smp[5] && !st_reg.ls_stop && st_reg.opt_wdt;
      st_next.tmr = smp[5] && !st_reg.ls_stop && timer8_use_lowspeed;
      // settle counter: crystal rising edges while enabled, saturating
      st_next.x1_prev = smp[1];
      if (!st_reg.mx_en) begin
         st_next.settle = clk_sel_pkg::BYTE_ZERO;
      end else if (smp[1] && !st_reg.x1_prev && st_reg.settle != clk_sel_pkg::SETTLE_MAX) begin
         st_next.settle = st_reg.settle + clk_sel_pkg::SETTLE_ONE;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // reset puts every select on the internal high-speed clock
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= '0;
         st_reg.waitreq <= 1'h1;
         st_reg.main_stop <= clk_sel_pkg::MAIN_STOP_RST;
         st_reg.ls_en <= 1'h1;
         st_reg.hs_en <= 1'h1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign readdata = {24'h000000, st_reg.rdata};
   assign waitrequest = st_reg.waitreq;
   assign hs_osc_enable = st_reg.hs_en;
   assign main_xtal_enable = st_reg.mx_en;
   assign main_ext_enable = st_reg.me_en;
   assign sub_xtal_enable = st_reg.sx_en;
   assign sub_ext_enable = st_reg.se_en;
   assign lowspeed_osc_enable = st_reg.ls_en;
   assign wdt_clk = st_reg.wdt;
   assign timer8_clk = st_reg.tmr;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sub_flag_a: assert property (read && !waitrequest && address == clk_sel_pkg::OFF_CPU_CTRL
      |-> readdata[clk_sel_pkg::B_ON_SUB] == ($past(cpu_cur) == clk_sel_pkg::SRC_SUB)) else $error("sub flag wrong");
   sub_block_a: assert property (!st_reg.pin_ovr && !st_reg.sub_en |=> !sub_xtal_enable && !sub_ext_enable)
      else $error("sub clock not blocked");
   stop_keeps_sub_a: assert property ($rose(stop_mode) && (sub_xtal_enable || sub_ext_enable) && !we
      |=> $stable(sub_xtal_enable) && $stable(sub_ext_enable)) else $error("stop mode halted sub clock");
   ls_stop_a: assert property (st_reg.ls_stop |=> !wdt_clk && !timer8_clk && !lowspeed_osc_enable)
      else $error("low-speed clock ran while stopped");
   ls_restart_a: assert property (we && address == clk_sel_pkg::OFF_INT_OSC && !writedata[clk_sel_pkg::B_LS_STOP]
      |=> !st_reg.ls_stop ##1 lowspeed_osc_enable) else $error("low-speed not restarted");
   ls_locked_a: assert property (st_reg.opt_lock |-> !st_reg.ls_stop)
      else $error("locked low-speed stopped");
   per_sel_a: assert property (!st_reg.src_sel && !st_reg.cpu_sub |-> per_sel == clk_sel_pkg::SRC_HS
      && cpu_sel == clk_sel_pkg::SRC_HS) else $error("main select wrong");
   hs_stop_a: assert property (we && address == clk_sel_pkg::OFF_INT_OSC && cpu_cur == clk_sel_pkg::SRC_HS
      && !st_reg.hs_stop |=> !st_reg.hs_stop ##1 (hs_osc_enable || $past(stop_mode))) else $error("stopped live clock");
   amp_once_a: assert property (st_reg.amp_locked |=> $stable(st_reg.amp_hi))
      else $error("gain changed twice");
   bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer timing");

   cpu_sub_cov: cover property (cpu_cur == clk_sel_pkg::SRC_SUB);
   cpu_hsys_cov: cover property (cpu_cur == clk_sel_pkg::SRC_X1 || cpu_cur == clk_sel_pkg::SRC_EXT);
   per_hsys_cov: cover property (per_cur != clk_sel_pkg::SRC_HS);
   ls_stop_cov: cover property (st_reg.ls_stop ##1 !st_reg.ls_stop);
endmodule : cpu_periph_clock_select

// *** logic/glitch_free_mux.sv ***
`timescale 1ns/1ps
// sampled-clock switch: moves to a new source only while old and new are low
module glitch_free_mux (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // sampled sources and wanted source
   input wire logic [clk_sel_pkg::NUM_SRC-1:0] src,
   input wire logic [1:0] sel,
   // switched clock and source actually in use
   output logic clk_out,
   output logic [1:0] cur
);
   typedef struct packed {
      logic [1:0] cur; // source in use
      logic out;       // switched clock level
   } mux_type;
   mux_type st_reg, st_next;

   // switch only in a common low phase, so no runt high or shortened low appears
   always_comb begin
      st_next = st_reg;
      if (sel != st_reg.cur && !src[st_reg.cur] && !src[sel] && !st_reg.out) begin
         st_next.cur = sel;
      end
      st_next.out = src[st_next.cur];
   end

   // state register, starts on the internal high-speed source
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= '{cur: clk_sel_pkg::SRC_HS, out: 1'h0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign clk_out = st_reg.out;
   assign cur = st_reg.cur;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   switch_low_a: assert property ($changed(st_reg.cur) |-> !$past(st_reg.out) && !st_reg.out)
      else $error("source changed outside a low phase");
   switch_cov: cover property ($changed(st_reg.cur));
endmodule : glitch_free_mux

// *** logic/sync2.sv ***
`timescale 1ns/1ps
// two-stage synchroniser for one level from outside the mclk domain
module sync2 (
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // level in and synchronised level out
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1; // first stage, read only by the second
      logic s2; // second stage
   } sync_type;
   sync_type st_reg, st_next;

   // next state
   always_comb begin
      st_next = st_reg;
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
   end

   // state register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign dout = st_reg.s2;
endmodule : sync2

// *** shared/clk_sel_pkg.sv ***
package clk_sel_pkg;
   // ---------------------------------------------------------------
   // register byte offsets on the slave bus
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_MAIN_MODE = 8'h00; // main_clock_mode
   localparam logic [7:0] OFF_CPU_CTRL = 8'h04;  // cpu_clock_control
   localparam logic [7:0] OFF_OSC_MODE = 8'h08;  // oscillator_mode_select
   localparam logic [7:0] OFF_MAIN_OSC = 8'h0C;  // main_oscillator_control
   localparam logic [7:0] OFF_INT_OSC = 8'h10;   // internal oscillator control
   localparam logic [7:0] OFF_SETTLE = 8'h14;    // settle counter, read only
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int B_SRC_SEL = 2;     // main_source_select
   localparam int B_MAIN_HS = 1;     // main_is_hs_flag, read only
   localparam int B_CPU_SRC = 0;     // main_cpu_source_select
   localparam int B_PIN_OVR = 6;     // sub_pin_override
   localparam int B_ON_SUB = 5;      // cpu_on_sub_flag, read only
   localparam int B_CPU_SUB = 4;     // cpu_sub_select
   localparam int B_EXT_MAIN = 7;    // main_ext_clock_select
   localparam int B_PINS_OSC = 6;    // main_pins_osc_mode
   localparam int B_SUB_EXT = 5;     // sub_ext_clock_select
   localparam int B_SUB_EN = 4;      // sub_osc_enable
   localparam int B_AMP_HI = 0;      // main_amp_high_gain
   localparam int B_MAIN_STOP = 7;   // main_clock_stop
   localparam int B_HS_READY = 7;    // internal high-speed running, read only
   localparam int B_LS_STOP = 1;     // lowspeed_osc_stop
   localparam int B_HS_STOP = 0;     // internal_hs_stop
   // ---------------------------------------------------------------
   // reset values and limits
   // ---------------------------------------------------------------
   localparam logic MAIN_STOP_RST = 1'h1; // main oscillator starts stopped
   localparam logic [7:0] SETTLE_MAX = 8'hFF;
   localparam logic [7:0] SETTLE_ONE = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ---------------------------------------------------------------
   // clock source codes for the switch
   // ---------------------------------------------------------------
   localparam logic [1:0] SRC_HS = 2'h0;  // internal high-speed
   localparam logic [1:0] SRC_X1 = 2'h1;  // main crystal
   localparam logic [1:0] SRC_EXT = 2'h2; // external main clock
   localparam logic [1:0] SRC_SUB = 2'h3; // subsystem clock
   localparam int NUM_SRC = 4;
   localparam int NUM_SYNC = 6;           // sampled oscillator inputs
endpackage : clk_sel_pkg

// *** sim/tb_cpu_periph_clock_select.sv ***
`timescale 1ns/1ps
module tb_cpu_periph_clock_select;
   logic mclk, sys_rst, read, write, waitrequest, stop_mode, timer8_use_lowspeed, opt_wdt_enable, opt_lowspeed_locked;
   logic [7:0] address, q, cnt;
   logic [31:0] writedata, readdata;
   logic [5:0] en; // hs, main xtal, main ext, sub xtal, sub ext, low-speed
   logic cpu_clk, periph_clk, wdt_clk, timer8_clk;
   int n_errors = 0, samples_checked = 0, cycles = 0;
   // row: address, write data, read mask, expected read, expected enables
   logic [39:0] rows[13] = '{{clk_sel_pkg::OFF_OSC_MODE, 8'h41, 8'hFF, 8'h41, 8'h21},
      {clk_sel_pkg::OFF_MAIN_OSC, 8'h00, 8'hFF, 8'h00, 8'h31}, {clk_sel_pkg::OFF_OSC_MODE, 8'hC0, 8'hFF, 8'hC1, 8'h29},
      {clk_sel_pkg::OFF_OSC_MODE, 8'hD0, 8'hFF, 8'hD1, 8'h2D}, {clk_sel_pkg::OFF_OSC_MODE, 8'hF0, 8'hFF, 8'hF1, 8'h2B},
      {clk_sel_pkg::OFF_CPU_CTRL, 8'h40, 8'h50, 8'h40, 8'h2D}, {clk_sel_pkg::OFF_CPU_CTRL, 8'h00, 8'h50, 8'h00, 8'h2B},
      {clk_sel_pkg::OFF_OSC_MODE, 8'hC0, 8'hFF, 8'hC1, 8'h29}, {clk_sel_pkg::OFF_INT_OSC, 8'h02, 8'h03, 8'h02, 8'h28},
      {clk_sel_pkg::OFF_INT_OSC, 8'h00, 8'h03, 8'h00, 8'h29}, {clk_sel_pkg::OFF_INT_OSC, 8'h01, 8'h03, 8'h00, 8'h29},
      {8'h18, 8'hFF, 8'hFF, 8'h00, 8'h29}, {clk_sel_pkg::OFF_MAIN_MODE, 8'h07, 8'h05, 8'h05, 8'h29}};
   // ---------------------------------------------------------------
   // clock, slow oscillator levels, timeout
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // oscillators well below mclk so the sampling switch can see them
   always @(posedge mclk) begin
      cnt <= cnt + 8'h01;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   cpu_periph_clock_select i_cpu_periph_clock_select (.mclk(mclk), .sys_rst(sys_rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
      .waitrequest(waitrequest), .hs_osc_clk(cnt[1]), .x1_clk(cnt[2]), .ext_main_clk(cnt[3]), .sub_xt_clk(cnt[4]),
      .sub_ext_clk(cnt[3]), .lowspeed_clk(cnt[2]), .opt_wdt_enable(opt_wdt_enable),
      .opt_lowspeed_locked(opt_lowspeed_locked), .stop_mode(stop_mode), .timer8_use_lowspeed(timer8_use_lowspeed),
      .hs_osc_enable(en[5]), .main_xtal_enable(en[4]), .main_ext_enable(en[3]), .sub_xtal_enable(en[2]),
      .sub_ext_enable(en[1]), .lowspeed_osc_enable(en[0]), .cpu_clk(cpu_clk), .periph_clk(periph_clk),
      .wdt_clk(wdt_clk), .timer8_clk(timer8_clk));
   // ---------------------------------------------------------------
   // bus, compare and closing tasks
   // ---------------------------------------------------------------
   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h0, d};
      do @(posedge mclk); while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // status polls give the switch time to move; bounded count
   task automatic poll(input logic [7:0] a, input int b);
      for (int i = 0; i < 80; i++) begin
         bus(1'b0, a, 8'h00);
         if (q[b] === 1'b1) break;
      end
      chk("status flag", 8'h01, {7'h0, q[b]});
   endtask : poll
   task automatic do_reset(input logic lock);
      sys_rst <= 1'b1;
      opt_lowspeed_locked <= lock;
      opt_wdt_enable <= lock;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : do_reset
   task automatic complete_run();
      $display("errors %0d, checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {read, write, stop_mode, timer8_use_lowspeed, cnt, address, writedata} = '0;
      {sys_rst, opt_wdt_enable, opt_lowspeed_locked} = 3'b100;
      do_reset(1'b0);
      chk("enables after reset", 8'h21, {2'b0, en});
      bus(1'b0, clk_sel_pkg::OFF_MAIN_OSC, 8'h00);
      chk("main osc reset", 8'h80, q);
      foreach (rows[i]) begin
         bus(1'b1, rows[i][39:32], rows[i][31:24]);
         repeat (2) @(posedge mclk);
         chk("enables", rows[i][7:0], {2'b0, en});
         bus(1'b0, rows[i][39:32], 8'h00);
         chk("readback", rows[i][15:8], q & rows[i][23:16]);
      end
      poll(clk_sel_pkg::OFF_MAIN_MODE, clk_sel_pkg::B_MAIN_HS);
      bus(1'b1, clk_sel_pkg::OFF_INT_OSC, 8'h01);
      repeat (2) @(posedge mclk);
      chk("hs stop off hs", 8'h00, {7'h0, en[5]});
      bus(1'b1, clk_sel_pkg::OFF_OSC_MODE, 8'hF0);
      bus(1'b1, clk_sel_pkg::OFF_CPU_CTRL, 8'h10);
      poll(clk_sel_pkg::OFF_CPU_CTRL, clk_sel_pkg::B_ON_SUB);
      stop_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("sub in stop", 8'h01, {7'h0, en[1]});
      stop_mode <= 1'b0;
      // second reset with the low-speed oscillator locked on
      do_reset(1'b1);
      bus(1'b0, clk_sel_pkg::OFF_MAIN_MODE, 8'h00);
      chk("mode after reset", 8'h00, q);
      bus(1'b1, clk_sel_pkg::OFF_INT_OSC, 8'h02);
      repeat (2) @(posedge mclk);
      chk("locked low-speed", 8'h01, {7'h0, en[0]});
      repeat (40) @(posedge mclk) if (wdt_clk === 1'b1) break;
      chk("watchdog clock", 8'h01, {7'h0, wdt_clk});
      chk("timer clock unselected", 8'h00, {7'h0, timer8_clk});
      timer8_use_lowspeed <= 1'b1;
      repeat (40) @(posedge mclk) if (timer8_clk === 1'b1) break;
      chk("timer clock", 8'h01, {7'h0, timer8_clk});
      // main crystal: gain and pin mode first, settle count watched before the switch
      bus(1'b0, clk_sel_pkg::OFF_SETTLE, 8'h00);
      chk("settle while off", 8'h00, q);
      bus(1'b1, clk_sel_pkg::OFF_OSC_MODE, 8'h40);
      bus(1'b1, clk_sel_pkg::OFF_MAIN_OSC, 8'h00);
      poll(clk_sel_pkg::OFF_SETTLE, 2);
      bus(1'b1, clk_sel_pkg::OFF_MAIN_MODE, 8'h05);
      poll(clk_sel_pkg::OFF_MAIN_MODE, clk_sel_pkg::B_MAIN_HS);
      repeat (40) @(posedge mclk) if (cpu_clk === 1'b1 && periph_clk === 1'b1) break;
      chk("switched clocks", 8'h03, {6'h0, cpu_clk, periph_clk});
      complete_run();
   end
endmodule : tb_cpu_periph_clock_select
